// *** hdl/utmc_top.sv ***
// UART transmit mode control: serial register port, transmit framing,
// automatic queue reload and host data output drive.
// Assumes all inputs, including the serial clock, are synchronous to mclk.
module utmc_top
	import utmc_pkg::*;
#(
	parameter int DW = 8
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic chip_select_n,
	input wire logic sclk,
	input wire logic sdi,
	output logic sdo,
	output logic sdo_en_n,
	input wire logic q_valid,
	input wire logic [DW-1:0] q_data,
	input wire logic q_last,
	output logic q_ready,
	input wire logic rx_full,
	input wire logic preamble_rx,
	input wire logic proc_active,
	input wire logic keepalive_req,
	output logic next_queue_load_command,
	output logic keepalive_enable,
	output logic tx_char_valid,
	output logic [1:0] tx_char_kind,
	output logic [DW-1:0] tx_char,
	input wire logic tx_char_ready,
	output logic tx_busy,
	output logic tx_idle,
	output logic rx_store_en
);
	// Framing and the register port are built for 8-bit characters only.
	if (DW != 8) begin
		$error("utmc_top: only 8-bit characters are supported");
	end

	// ==========================================================
	// Serial register port
	// ==========================================================
	logic sclk_d, next_sclk_d;
	logic [3:0] bit_cnt, next_bit_cnt;
	logic [7:0] shift_in, next_shift_in;
	logic [7:0] shift_out, next_shift_out;
	logic [7:0] addr, next_addr;
	logic [7:0] gen3, next_gen3;
	logic [7:0] txmode, next_txmode;
	logic next_sdo, next_sdo_en_n;
	logic rise, fall;

	// Read data decode, shared by the shift loader.
	function automatic logic [7:0] read_value(input logic [7:0] a,
			input logic [7:0] g3, input logic [7:0] tm);
		if (a == ADDR_GEN3_RD) begin
			read_value = {1'b0, g3[6:0]};
		end else if (a == ADDR_TXMODE_RD) begin
			read_value = tm;
		end else begin
			read_value = 8'h00;
		end
	endfunction

	// Mode 0 framing: sample on rising, shift out on falling edges.
	always_comb begin
		next_sclk_d = sclk;
		rise = sclk && !sclk_d && !chip_select_n;
		fall = !sclk && sclk_d && !chip_select_n;
		next_bit_cnt = bit_cnt;
		next_shift_in = shift_in;
		next_shift_out = shift_out;
		next_addr = addr;
		next_gen3 = gen3;
		next_txmode = txmode;
		next_sdo = sdo;
		if (chip_select_n) begin
			next_bit_cnt = 4'h0;
			next_sdo = 1'b0;
		end else begin
			if (rise) begin
				next_shift_in = {shift_in[6:0], sdi};
				next_bit_cnt = bit_cnt + 4'h1;
				if (bit_cnt == SPI_ADDR_BITS - 4'h1) begin
					next_addr = {shift_in[6:0], sdi};
					next_shift_out = read_value({shift_in[6:0], sdi},
						gen3, txmode);
				end
				if (bit_cnt == SPI_LAST_BIT) begin
					if (addr == ADDR_GEN3_WR) begin
						// Reserved top bit is never stored.
						next_gen3 = {1'b0, shift_in[5:0], sdi};
					end else if (addr == ADDR_TXMODE_WR) begin
						next_txmode = {shift_in[6:0], sdi};
					end
				end
			end
			if (fall && bit_cnt >= SPI_ADDR_BITS) begin
				next_sdo = shift_out[7];
				next_shift_out = {shift_out[6:0], 1'b0};
			end
		end
		// Low enable means the pin is driven.
		next_sdo_en_n = !(gen3[G3_DOUT] || !chip_select_n);
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			sclk_d <= 1'b0;
			bit_cnt <= 4'h0;
			shift_in <= 8'h00;
			shift_out <= 8'h00;
			addr <= 8'h00;
			gen3 <= GEN3_RESET;
			txmode <= TXMODE_RESET;
			sdo <= 1'b0;
			sdo_en_n <= 1'b1;
		end else begin
			sclk_d <= next_sclk_d;
			bit_cnt <= next_bit_cnt;
			shift_in <= next_shift_in;
			shift_out <= next_shift_out;
			addr <= next_addr;
			gen3 <= next_gen3;
			txmode <= next_txmode;
			sdo <= next_sdo;
			sdo_en_n <= next_sdo_en_n;
		end
	end

	// ==========================================================
	// Queue buffer
	// ==========================================================
	utmc_buf_if #(.W(DW + 1)) qbus ();
	logic pop;

	utmc_buf #(.W(DW + 1)) u_buf (
		.mclk(mclk),
		.rst(rst),
		.bus(qbus.store)
	);

	assign qbus.in_valid = q_valid;
	assign qbus.in_data = {q_last, q_data};
	assign qbus.out_ready = pop;
	assign q_ready = qbus.in_ready;

	// ==========================================================
	// Automatic queue load and keep-alive enable
	// ==========================================================
	logic next_nql, next_ka_en;

	// Pulse follows the preamble by one cycle so it stays registered.
	always_comb begin
		next_nql = gen3[G3_AUTO] && preamble_rx && !proc_active;
		next_ka_en = gen3[G3_KA_LSB +: 4] != KA_DISABLED;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			next_queue_load_command <= 1'b0;
			keepalive_enable <= 1'b0;
		end else begin
			next_queue_load_command <= next_nql;
			keepalive_enable <= next_ka_en;
		end
	end

	// ==========================================================
	// Transmit framing
	// ==========================================================
	utmc_state_t state, next_state;
	logic [7:0] len, next_len;
	logic frame_open, next_frame_open;
	logic discard, next_discard;
	logic next_valid, next_busy, next_idle, next_store;
	logic [1:0] next_kind;
	logic [DW-1:0] next_char;
	logic issue, can_issue, halt, last_in;
	logic [7:0] limit;

	// The hold bit gates every issue, so a character already handed to the
	// line completes while nothing new starts and status stays as it was.
	always_comb begin
		halt = txmode[TM_PAUSE];
		can_issue = !halt && (!tx_char_valid || tx_char_ready);
		limit = gen3[G3_UNLIM] ? LEN_UNLIM : LEN_DEFAULT;
		last_in = qbus.out_data[DW];
		next_state = state;
		next_len = len;
		next_frame_open = frame_open;
		next_discard = discard;
		next_busy = tx_busy;
		next_store = rx_store_en;
		issue = 1'b0;
		next_kind = tx_char_kind;
		next_char = tx_char;
		pop = 1'b0;
		unique case (state)
			ST_IDLE: begin
				if (discard && qbus.out_valid) begin
					// Bytes past the length cap are dropped to message end.
					pop = 1'b1;
					next_discard = !last_in;
				end else if (can_issue && txmode[TM_PREAMBLES]) begin
					issue = 1'b1;
					next_kind = KIND_PRE;
				end else if (can_issue && txmode[TM_QUEUE] && qbus.out_valid
						&& (!rx_full || gen3[G3_UNLIM])) begin
					next_busy = 1'b1;
					next_len = 8'h00;
					if (txmode[TM_NOPRE]) begin
						// Continuing an open frame keeps storing.
						next_store = frame_open;
						next_state = ST_DATA;
					end else begin
						next_store = 1'b1;
						next_frame_open = 1'b1;
						next_state = ST_PRE;
					end
				end else if (can_issue && keepalive_req && keepalive_enable) begin
					issue = 1'b1;
					next_kind = KIND_STOP;
				end
			end
			ST_PRE: begin
				if (can_issue) begin
					issue = 1'b1;
					next_kind = KIND_PRE;
					next_state = ST_DATA;
				end
			end
			ST_DATA: begin
				if (can_issue && qbus.out_valid) begin
					issue = 1'b1;
					pop = 1'b1;
					next_kind = KIND_DATA;
					next_char = qbus.out_data[DW-1:0];
					next_len = len + 8'h01;
					if (last_in || next_len == limit) begin
						// The end state decides on the stop character.
						next_discard = !last_in;
						next_state = ST_STOP;
					end
				end
			end
			ST_STOP: begin
				// Busy stays up until the last data character is taken, so
				// no data character is ever offered outside a message.
				if (can_issue) begin
					if (!txmode[TM_NOSTOP]) begin
						issue = 1'b1;
						next_kind = KIND_STOP;
						next_frame_open = 1'b0;
					end
					next_busy = 1'b0;
					next_state = ST_IDLE;
				end
			end
		endcase
		next_valid = issue || (tx_char_valid && !tx_char_ready);
		next_idle = !next_busy;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state <= ST_IDLE;
			len <= 8'h00;
			frame_open <= 1'b0;
			discard <= 1'b0;
			tx_char_valid <= 1'b0;
			tx_char_kind <= KIND_DATA;
			tx_char <= '0;
			tx_busy <= 1'b0;
			tx_idle <= 1'b1;
			rx_store_en <= 1'b0;
		end else begin
			state <= next_state;
			len <= next_len;
			frame_open <= next_frame_open;
			discard <= next_discard;
			tx_char_valid <= next_valid;
			tx_char_kind <= next_kind;
			tx_char <= next_char;
			tx_busy <= next_busy;
			tx_idle <= next_idle;
			rx_store_en <= next_store;
		end
	end
endmodule

// *** hdl/utmc_pkg.sv ***
// Constants, register map and types for the UART transmit mode control block.
// Assumes a single 100 MHz clock and a synchronous active-high reset.
package utmc_pkg;

	// ==========================================================
	// Register addresses on the serial host port
	// ==========================================================
	localparam logic [7:0] ADDR_GEN3_WR = 8'h66;
	localparam logic [7:0] ADDR_GEN3_RD = 8'h67;
	localparam logic [7:0] ADDR_TXMODE_WR = 8'h64;
	localparam logic [7:0] ADDR_TXMODE_RD = 8'h65;

	// ==========================================================
	// Reset values
	// ==========================================================
	localparam logic [7:0] GEN3_RESET = 8'h0f;
	localparam logic [7:0] TXMODE_RESET = 8'h10;

	// ==========================================================
	// Field positions
	// ==========================================================
	localparam int TM_NOPRE = 0;
	localparam int TM_NOSTOP = 1;
	localparam int TM_PAUSE = 2;
	localparam int TM_QUEUE = 4;
	localparam int TM_PREAMBLES = 5;
	localparam int G3_KA_LSB = 0;
	localparam int G3_DOUT = 4;
	localparam int G3_UNLIM = 5;
	localparam int G3_AUTO = 6;
	localparam int G3_RSVD = 7;
	localparam logic [3:0] KA_DISABLED = 4'hf;

	// ==========================================================
	// Message length limits and serial frame size
	// ==========================================================
	localparam logic [7:0] LEN_DEFAULT = 8'h56;
	localparam logic [7:0] LEN_UNLIM = 8'hff;
	localparam logic [3:0] SPI_ADDR_BITS = 4'h8;
	localparam logic [3:0] SPI_LAST_BIT = 4'hf;

	// ==========================================================
	// Character kinds and transmitter states
	// ==========================================================
	localparam logic [1:0] KIND_DATA = 2'h0;
	localparam logic [1:0] KIND_PRE = 2'h1;
	localparam logic [1:0] KIND_STOP = 2'h2;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_PRE = 4'h2,
		ST_DATA = 4'h4,
		ST_STOP = 4'h8
	} utmc_state_t;

endpackage

// *** hdl/utmc_buf_if.sv ***
// Valid/ready carrier between the transmit queue buffer and its user.
// Assumes both ends run on the same clock.
interface utmc_buf_if #(
	parameter int W = 9
);
	logic in_valid;
	logic [W-1:0] in_data;
	logic in_ready;
	logic out_valid;
	logic [W-1:0] out_data;
	logic out_ready;

	modport store (
		input in_valid,
		input in_data,
		output in_ready,
		output out_valid,
		output out_data,
		input out_ready
	);
	modport user (
		output in_valid,
		output in_data,
		input in_ready,
		input out_valid,
		input out_data,
		output out_ready
	);
endinterface

// *** hdl/utmc_buf.sv ***
// Two-entry buffer in the transmit queue data path.
// Assumes the user side pops only while out_valid is high.
module utmc_buf
	import utmc_pkg::*;
#(
	parameter int W = 9
) (
	input wire logic mclk,
	input wire logic rst,
	utmc_buf_if.store bus
);
	// ==========================================================
	// Storage
	// ==========================================================
	logic [W-1:0] mem [2];
	logic [W-1:0] next_mem [2];
	logic wr_ptr, next_wr_ptr;
	logic rd_ptr, next_rd_ptr;
	logic [1:0] count, next_count;
	logic not_full, next_not_full;
	logic push, pop;

	// A zero-width entry cannot carry the last-byte marker.
	if (W < 1) begin
		$error("utmc_buf: width must be at least one");
	end

	// Ready is registered so a stalled reader pushes back on the source.
	always_comb begin
		push = bus.in_valid && not_full;
		pop = bus.out_ready && (count != 2'h0);
		next_mem = mem;
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		if (push) begin
			next_mem[wr_ptr] = bus.in_data;
			next_wr_ptr = ~wr_ptr;
		end
		if (pop) begin
			next_rd_ptr = ~rd_ptr;
		end
		next_count = count + {1'b0, push} - {1'b0, pop};
		next_not_full = (next_count != 2'h2);
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			mem[0] <= '0;
			mem[1] <= '0;
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count <= 2'h0;
			not_full <= 1'b1;
		end else begin
			mem <= next_mem;
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
			not_full <= next_not_full;
		end
	end

	assign bus.in_ready = not_full;
	assign bus.out_valid = (count != 2'h0);
	assign bus.out_data = mem[rd_ptr];
endmodule

// *** verification/utmc_properties.sv ***
// Port-level checker for the transmit mode control block.
// Assumes it is bound to utmc_top and sees only that module's ports.
module utmc_properties
	import utmc_pkg::*;
#(
	parameter int DW = 8
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic chip_select_n,
	input wire logic sdo,
	input wire logic preamble_rx,
	input wire logic proc_active,
	input wire logic next_queue_load_command,
	input wire logic keepalive_enable,
	input wire logic tx_char_valid,
	input wire logic [1:0] tx_char_kind,
	input wire logic [DW-1:0] tx_char,
	input wire logic tx_char_ready,
	input wire logic tx_busy,
	input wire logic tx_idle
);
	// ==========================================================
	// Assertions
	// ==========================================================
	// All checks share one clock and are off while reset is high.
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_load_cause:
	assert property (next_queue_load_command |-> $past(preamble_rx))
		else $error("queue load without a preamble");
	a_load_quiet:
	assert property (proc_active |=> !next_queue_load_command)
		else $error("queue load during a busy process");
	a_char_held:
	assert property (tx_char_valid && !tx_char_ready |=> tx_char_valid &&
		$stable(tx_char) && $stable(tx_char_kind))
		else $error("character dropped before taken");
	a_status_pair:
	assert property (tx_busy != tx_idle)
		else $error("busy and idle agree");
	a_desel_quiet:
	assert property (chip_select_n [*2] |-> !sdo)
		else $error("read data while deselected");
	a_kind_legal:
	assert property (tx_char_valid |-> tx_char_kind != 2'h3)
		else $error("illegal character kind");
	a_data_in_msg:
	assert property (tx_char_valid && tx_char_kind == KIND_DATA |-> tx_busy)
		else $error("data outside a message");
	a_ka_reset:
	assert property ($fell(rst) |-> !keepalive_enable)
		else $error("keep-alive enabled after reset");

	// Main scenarios worth seeing at least once.
	c_load: cover property (next_queue_load_command);
	c_data: cover property (tx_char_valid && tx_char_ready &&
		tx_char_kind == KIND_DATA);
	c_stop: cover property (tx_char_valid && tx_char_ready &&
		tx_char_kind == KIND_STOP);
endmodule

// *** verification/utmc_line_model.sv ***
// Model of the daisy-chained devices on the UART line.
// Assumes one clock shared with the block; logs every taken character.
module utmc_line_model (
	input wire logic mclk,
	input wire logic rst,
	input wire logic slow,
	input wire logic tx_char_valid,
	input wire logic [1:0] tx_char_kind,
	input wire logic [7:0] tx_char,
	output logic tx_char_ready,
	output logic preamble_rx
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [9:0] seen[$];
	logic ph = 1'b0;

	initial preamble_rx = 1'b0;
	// A slow line accepts only every other cycle, to stall the sender.
	always @(posedge mclk) begin
		if (tx_char_valid && tx_char_ready)
			seen.push_back({tx_char_kind, tx_char});
		ph <= ~ph;
		tx_char_ready <= #1 !rst && (!slow || ph);
	end

	// One returning preamble as seen from the chain.
	task automatic pulse_pre();
		@(posedge mclk);
		#1 preamble_rx = 1'b1;
		@(posedge mclk);
		#1 preamble_rx = 1'b0;
		repeat (3) @(posedge mclk);
		#1;
	endtask
endmodule

// *** verification/tb_top.sv ***
// Self-checking bench for the transmit mode control block.
// Assumes the line model answers characters and the bench drives all else.
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; \
	$display("wrong value t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import utmc_pkg::*;
	logic mclk = 0, rst = 1, chip_select_n = 1, sclk = 0, sdi = 0;
	logic q_valid = 0, q_last = 0, rx_full = 0, proc_active = 0;
	logic keepalive_req = 0, slow = 0, stored = 0;
	logic [7:0] q_data = 8'h00, tx_char, rd;
	logic sdo, sdo_en_n, q_ready, preamble_rx, next_queue_load_command;
	logic keepalive_enable, tx_char_valid, tx_char_ready, tx_busy, tx_idle;
	logic rx_store_en;
	logic [1:0] tx_char_kind;
	int miscompares = 0, checks_done = 0, loads = 0;

	utmc_top DUT (.mclk, .rst, .chip_select_n, .sclk, .sdi, .sdo, .sdo_en_n,
		.q_valid, .q_data, .q_last, .q_ready, .rx_full, .preamble_rx,
		.proc_active, .keepalive_req, .next_queue_load_command,
		.keepalive_enable, .tx_char_valid, .tx_char_kind, .tx_char,
		.tx_char_ready, .tx_busy, .tx_idle, .rx_store_en);
	utmc_line_model P (.mclk, .rst, .slow, .tx_char_valid, .tx_char_kind,
		.tx_char, .tx_char_ready, .preamble_rx);

	// ==========================================================
	// Clock, monitors and watchdog
	// ==========================================================
	initial forever #5 mclk = ~mclk;
	// A data character taken while storing is enabled counts as stored;
	// queue loads are pulses, so they are counted here.
	always @(posedge mclk) begin
		if (rx_store_en && tx_char_valid && tx_char_ready &&
			tx_char_kind == KIND_DATA) stored <= 1'b1;
		if (next_queue_load_command) loads++;
	end
	// The run needs about 3000 cycles, so 30000 cycles means a hang.
	initial begin
		#300000;
		miscompares++;
		conclude();
	end

	// ==========================================================
	// Tasks
	// ==========================================================
	task automatic conclude();
		$display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// One register frame; slow edges keep each phase for three samples.
	task automatic spi(input logic [7:0] a, input logic [7:0] d);
		chip_select_n = 0;
		for (int i = 15; i >= 0; i--) begin
			sdi = i > 7 ? a[i-8] : d[i];
			sclk = 0;
			repeat (3) @(posedge mclk);
			#1 rd[i%8] = sdo;
			sclk = 1;
			repeat (3) @(posedge mclk);
			#1;
		end
		chip_select_n = 1;
		sclk = 0;
		repeat (3) @(posedge mclk);
		#1;
	endtask
	task automatic push(input int n);
		for (int i = 0; i < n; i++) begin
			q_valid = 1;
			q_data = 8'h30 + 8'(i);
			q_last = i == n - 1;
			@(posedge mclk);
			while (!q_ready) @(posedge mclk);
			#1;
		end
		q_valid = 0;
		q_last = 0;
	endtask
	// Sends n bytes in one mode and compares the whole line output.
	task automatic msg(input logic [7:0] mode, input int n, input int sent,
		input int pre, input int stp);
		int k;
		k = sent + pre + stp;
		// Cleared first: a waiting message starts inside the register write.
		P.seen.delete();
		stored = 0;
		spi(ADDR_TXMODE_WR, mode);
		push(n);
		for (int i = 0; i < 3000 && P.seen.size() < k; i++) @(posedge mclk);
		repeat (20) @(posedge mclk);
		#1;
		`CHK(P.seen.size(), k)
		if (pre) `CHK(P.seen[0][9:8], KIND_PRE)
		for (int i = 0; i < sent; i++)
			`CHK(P.seen[i+pre], {KIND_DATA, 8'h30 + 8'(i)})
		if (stp) `CHK(P.seen[k-1][9:8], KIND_STOP)
	endtask
	task automatic idle_check();
		repeat (40) @(posedge mclk);
		#1;
		`CHK(P.seen.size(), 0)
		`CHK(tx_idle, 1'b1)
	endtask

	// ==========================================================
	// Scenarios
	// ==========================================================
	initial begin
		repeat (4) @(posedge mclk);
		#1 rst = 0;
		spi(ADDR_GEN3_RD, 8'h00);
		`CHK(rd, GEN3_RESET)
		`CHK(keepalive_enable, 1'b0)
		`CHK(sdo_en_n, 1'b1)
		spi(ADDR_TXMODE_RD, 8'h00);
		`CHK(rd, TXMODE_RESET)
		spi(ADDR_GEN3_WR, 8'hf0);
		spi(ADDR_GEN3_RD, 8'h00);
		`CHK(rd, 8'h70)
		`CHK(sdo_en_n, 1'b0)
		`CHK(keepalive_enable, 1'b1)
		P.pulse_pre();
		`CHK(loads, 1)
		proc_active = 1;
		P.pulse_pre();
		`CHK(loads, 1)
		proc_active = 0;
		// A keep-alive tick on an idle line yields one stop character.
		P.seen.delete();
		keepalive_req = 1;
		@(posedge mclk);
		#1 keepalive_req = 0;
		repeat (20) @(posedge mclk);
		#1;
		`CHK(P.seen.size(), 1)
		`CHK(P.seen[0][9:8], KIND_STOP)
		// Hold beats continuous preambles, then a queued message.
		spi(ADDR_TXMODE_WR, 8'h34);
		P.seen.delete();
		idle_check();
		spi(ADDR_TXMODE_WR, 8'h14);
		push(2);
		idle_check();
		`CHK(q_ready, 1'b0)
		msg(8'h10, 0, 2, 1, 1);
		// Length cap, and a slow line stalling a normal message.
		spi(ADDR_GEN3_WR, 8'h0f);
		msg(8'h10, 90, 86, 1, 1);
		slow = 1;
		msg(8'h10, 3, 3, 1, 1);
		slow = 0;
		spi(ADDR_GEN3_WR, 8'h2f);
		msg(8'h10, 90, 90, 1, 1);
		// An open frame continued without a preamble, then unframed data.
		msg(8'h12, 3, 3, 1, 0);
		msg(8'h13, 3, 3, 0, 0);
		`CHK(stored, 1'b1)
		msg(8'h11, 2, 2, 0, 1);
		msg(8'h11, 2, 2, 0, 1);
		`CHK(stored, 1'b0)
		// A full receive buffer blocks until long messages are allowed.
		rx_full = 1;
		spi(ADDR_GEN3_WR, 8'h0f);
		spi(ADDR_TXMODE_WR, 8'h10);
		P.seen.delete();
		push(2);
		idle_check();
		// Hold keeps the message back until msg starts watching the line.
		spi(ADDR_TXMODE_WR, 8'h14);
		spi(ADDR_GEN3_WR, 8'h2f);
		msg(8'h10, 0, 2, 1, 1);
		rx_full = 0;
		conclude();
	end
endmodule

bind utmc_top utmc_properties #(.DW(DW)) u_props (.mclk, .rst, .chip_select_n,
	.sdo, .preamble_rx, .proc_active, .next_queue_load_command,
	.keepalive_enable, .tx_char_valid, .tx_char_kind, .tx_char,
	.tx_char_ready, .tx_busy, .tx_idle);
